// ==== charge_pkg.sv ====
// Shared offsets, fields, reset values and timing for the charge supervisor
package charge_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_WDOG = 8'h04;
	localparam logic [7:0] OFF_SET  = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0c;
	// Control fields
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_KICK_BIT = 1;
	localparam int CTRL_MASK_BIT = 2;
	// Watchdog and setting fields
	localparam int WDOG_LSB = 0;
	localparam int WDOG_W   = 7;
	localparam int CUR_LSB  = 0;
	localparam int CUR_W    = 4;
	localparam int VOLT_LSB = 8;
	localparam int VOLT_W   = 6;
	// Status fields
	localparam int STAT_CHG_BIT   = 0;
	localparam int STAT_SW_BIT    = 1;
	localparam int STAT_TOK_BIT   = 2;
	localparam int STAT_PRES_BIT  = 3;
	localparam int STAT_TEV_BIT   = 4;
	localparam int STAT_PWROK_BIT = 5;
	// Reset values of the charge group
	localparam logic [WDOG_W-1:0] WDOG_RST = 7'h7f;
	localparam logic [CUR_W-1:0]  CUR_RST  = 4'h0;
	localparam logic [VOLT_W-1:0] VOLT_RST = 6'h00;
	// Timing
	localparam int CLK_NS    = 10;
	localparam int SECOND_NS = 1000000000;
	localparam int SEC_CYCLES = SECOND_NS / CLK_NS;
	typedef enum logic [1:0] {CHG_OFF, CHG_RUN, CHG_GATED} chg_state_t;
endpackage

// ==== charge_sync.sv ====
// Two-flop synchroniser for a group of level inputs
`timescale 1ns/1ps
module charge_sync #(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_t;
	sync_t r;
	sync_t n;
	always_comb
	begin
		n.s1 = async_in;
		n.s2 = r.s1;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= '0;
		else
			r <= n;
	end
	assign sync_out = r.s2;
endmodule // charge_sync

// ==== charge_wdog.sv ====
// Charging watchdog: seconds prescaler and down counter
`timescale 1ns/1ps
module charge_wdog #(
	parameter int TICK_CYCLES = 100,
	parameter int SEC_W       = 7
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Control
	input  wire logic             run,
	input  wire logic             load,
	input  wire logic [SEC_W-1:0] load_secs,
	// Status
	output logic                  expired,
	output logic      [SEC_W-1:0] secs_left
);
	localparam int PW = $clog2(TICK_CYCLES);
	if (TICK_CYCLES < 2)
	begin : g_chk
		$error("TICK_CYCLES must be at least 2");
	end
	typedef struct packed {
		logic [PW-1:0]    presc;
		logic [SEC_W-1:0] secs;
		logic             exp;
	} wd_t;
	wd_t r;
	wd_t n;
	always_comb
	begin
		n = r;
		n.exp = 1'b0;
		if (load)
		begin
			n.secs = load_secs;
			n.presc = '0;
		end
		else if (run)
		begin
			if (r.presc == PW'(TICK_CYCLES - 1))
			begin
				n.presc = '0;
				// Zero and one both expire, so a zero time still ends
				if (r.secs <= SEC_W'(1))
				begin
					n.exp = 1'b1;
					n.secs = '0;
				end
				else
					n.secs = r.secs - SEC_W'(1);
			end
			else
				n.presc = r.presc + PW'(1);
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= '0;
		else
			r <= n;
	end
	assign expired = r.exp;
	assign secs_left = r.secs;
endmodule // charge_wdog

// ==== charge_state_supervisor.sv ====
// Battery charge state supervisor with APB register access
// Overview of operation
// - A power reset clears every charger register and stops charging.
// - Primary watchdog, low battery or thermal trip pull power reset low.
// - Loss of the crystal oscillator stops charging and clears all state.
// - Warm reset stops charging, clears all state and the limit registers.
// - Kick or watchdog time write keeps charging in software timed mode.
// - Current or voltage writes keep charging and reset nothing.
// - Setting enable starts charging timed by the software watchdog field.
// - Clearing enable stops charging and resets the charge group.
// - Temperature is measured before start and watched during charging.
// - Out of window temperature gates charging, return resumes it.
// - A dead battery does not start charging outside the window.
// - A nonvolatile bit can disable temperature gating.
// - Temperature monitoring runs only while a charger is detected.
// - Every crossing of a temperature limit while a charger stays detected raises an interrupt.
// - A mask suppresses the temperature interrupt.
// - Charging needs both window comparators to report inside unless temp_gate_dis is set.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
module charge_state_supervisor
	import charge_pkg::*;
#(
	parameter int TICK_CYCLES = SEC_CYCLES
) (
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Power reset causes
	input  wire logic        prim_wdog_expired,
	input  wire logic        battery_low_threshold,
	input  wire logic        thermal_protect_flag,
	input  wire logic        pwr_off_req,
	input  wire logic        xtal_ok,
	input  wire logic        warm_reset_n,
	output logic             system_power_reset_n,
	output logic             limit_reset,
	// Charger detection and temperature window
	input  wire logic        vbus_det,
	input  wire logic        ext_chg_det,
	input  wire logic        temp_cold_ok,
	input  wire logic        temp_hot_ok,
	input  wire logic        temp_gate_dis,
	// Charger control
	output logic             temp_mon_en,
	output logic             charge_on,
	output logic [3:0]       charge_current_set,
	output logic [5:0]       charge_voltage_set,
	output logic             temp_irq
);
	if (TICK_CYCLES < 2)
	begin : g_chk
		$error("TICK_CYCLES must be at least 2");
	end

	typedef struct packed {
		chg_state_t         st;
		logic               en;
		logic               sw_mode;
		logic               mask;
		logic               temp_ev;
		logic               win_d;
		logic               mon_d;
		logic [WDOG_W-1:0]  wtime;
		logic [CUR_W-1:0]   cur;
		logic [VOLT_W-1:0]  volt;
		logic               pwr_ok;
		logic               limit_clr;
		logic [31:0]        rdata;
		logic               slverr;
	} sup_t;

	localparam sup_t RST = '{
		st: CHG_OFF,
		wtime: WDOG_RST,
		cur: CUR_RST,
		volt: VOLT_RST,
		default: '0
	};

	sup_t r;
	sup_t n;

	logic [3:0]        sync_s;
	logic              cold_s;
	logic              hot_s;
	logic              vbus_s;
	logic              ext_s;
	logic              present;
	logic              win;
	logic              temp_ok;
	logic              temp_cross;
	logic              pwr_bad;
	logic              all_clr;
	logic              group_clr;
	logic              setup;
	logic              access;
	logic              wr;
	logic              hit;
	logic              wd_load;
	logic [WDOG_W-1:0] wd_secs;
	logic              wd_expired;
	logic [WDOG_W-1:0] wd_left;
	logic              wd_run;

	// Raw comparator levels may change at any time
	charge_sync #(
		.W(4)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.async_in({temp_cold_ok, temp_hot_ok, vbus_det, ext_chg_det}),
		.sync_out(sync_s)
	);

	assign cold_s = sync_s[3];
	assign hot_s = sync_s[2];
	assign vbus_s = sync_s[1];
	assign ext_s = sync_s[0];

	assign present = vbus_s | ext_s;
	assign win = cold_s & hot_s;
	assign temp_ok = win | temp_gate_dis;
	// Only crossings seen while monitoring for two cycles count
	assign temp_cross = present & r.mon_d & (win != r.win_d);

	assign pwr_bad = prim_wdog_expired | battery_low_threshold |
		thermal_protect_flag | pwr_off_req;
	assign all_clr = !r.pwr_ok | !xtal_ok | !warm_reset_n;

	assign setup = psel & !penable;
	assign access = psel & penable;
	assign wr = access & pwrite;
	assign hit = (paddr == OFF_CTRL) | (paddr == OFF_WDOG) |
		(paddr == OFF_SET) | (paddr == OFF_STAT);

	assign wd_run = (r.st != CHG_OFF);

	always_comb
	begin
		n = r;
		wd_load = 1'b0;
		wd_secs = r.wtime;
		group_clr = wd_expired;
		n.limit_clr = !warm_reset_n;
		n.pwr_ok = !pwr_bad;
		n.mon_d = present;
		n.win_d = win;

		// Read data is captured in the setup cycle
		if (setup)
		begin
			n.rdata = '0;
			n.slverr = !hit;
			case (paddr)
				OFF_CTRL:
				begin
					n.rdata[CTRL_EN_BIT] = r.en;
					n.rdata[CTRL_MASK_BIT] = r.mask;
				end
				OFF_WDOG: n.rdata[WDOG_LSB +: WDOG_W] = r.wtime;
				OFF_SET:
				begin
					n.rdata[CUR_LSB +: CUR_W] = r.cur;
					n.rdata[VOLT_LSB +: VOLT_W] = r.volt;
				end
				OFF_STAT:
				begin
					n.rdata[STAT_CHG_BIT] = (r.st == CHG_RUN);
					n.rdata[STAT_SW_BIT] = r.sw_mode;
					n.rdata[STAT_TOK_BIT] = temp_ok;
					n.rdata[STAT_PRES_BIT] = present;
					n.rdata[STAT_TEV_BIT] = r.temp_ev;
					n.rdata[STAT_PWROK_BIT] = r.pwr_ok;
				end
				default: n.rdata = '0;
			endcase
		end

		// Register writes take effect in the access cycle
		if (wr)
		begin
			case (paddr)
				OFF_CTRL:
				begin
					n.mask = pwdata[CTRL_MASK_BIT];
					n.en = pwdata[CTRL_EN_BIT];
					if (pwdata[CTRL_EN_BIT] && !r.en)
						wd_load = 1'b1;
					if (!pwdata[CTRL_EN_BIT])
						group_clr = 1'b1;
					if (pwdata[CTRL_KICK_BIT])
					begin
						n.sw_mode = 1'b1;
						wd_load = 1'b1;
					end
				end
				OFF_WDOG:
				begin
					n.wtime = pwdata[WDOG_LSB +: WDOG_W];
					wd_secs = pwdata[WDOG_LSB +: WDOG_W];
					n.sw_mode = 1'b1;
					wd_load = 1'b1;
				end
				OFF_SET:
				begin
					// Watchdog keeps its count on a setting change
					n.cur = pwdata[CUR_LSB +: CUR_W];
					n.volt = pwdata[VOLT_LSB +: VOLT_W];
					n.sw_mode = 1'b1;
				end
				OFF_STAT:
				begin
					if (pwdata[STAT_TEV_BIT])
						n.temp_ev = 1'b0;
				end
				default: n = n;
			endcase
		end

		// Set wins over a same cycle status write clear
		if (temp_cross)
			n.temp_ev = 1'b1;

		// Start needs a detected charger, so the monitor runs first
		case (r.st)
			CHG_OFF:
			begin
				if (r.en && present)
					n.st = temp_ok ? CHG_RUN : CHG_GATED;
			end
			CHG_RUN:
			begin
				if (!temp_ok)
					n.st = CHG_GATED;
			end
			CHG_GATED:
			begin
				if (temp_ok)
					n.st = CHG_RUN;
			end
			default: n.st = CHG_OFF;
		endcase
		if (!r.en || !present)
			n.st = CHG_OFF;

		if (group_clr)
		begin
			n.st = CHG_OFF;
			n.en = 1'b0;
			n.sw_mode = 1'b0;
			n.wtime = WDOG_RST;
			n.cur = CUR_RST;
			n.volt = VOLT_RST;
		end

		// Full clear also drops mask and pending event
		if (all_clr)
		begin
			n.st = CHG_OFF;
			n.en = 1'b0;
			n.sw_mode = 1'b0;
			n.mask = 1'b0;
			n.temp_ev = 1'b0;
			n.wtime = WDOG_RST;
			n.cur = CUR_RST;
			n.volt = VOLT_RST;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= RST;
		else
			r <= n;
	end

	charge_wdog #(
		.TICK_CYCLES(TICK_CYCLES),
		.SEC_W      (WDOG_W)
	) u_wdog (
		.pclk     (pclk),
		.presetn  (presetn),
		.run      (wd_run),
		.load     (wd_load),
		.load_secs(wd_secs),
		.expired  (wd_expired),
		.secs_left(wd_left)
	);

	assign prdata = r.rdata;
	assign pready = access;
	assign pslverr = access & r.slverr;
	assign system_power_reset_n = r.pwr_ok;
	assign limit_reset = r.limit_clr;
	assign temp_mon_en = present;
	assign charge_on = (r.st == CHG_RUN);
	assign charge_current_set = r.cur;
	assign charge_voltage_set = r.volt;
	assign temp_irq = r.temp_ev & !r.mask;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	pwr_drop_a: assert property (
		pwr_bad |=> !system_power_reset_n
	) else $error("power reset not pulled low");

	pwr_clear_a: assert property (
		!system_power_reset_n |=> !r.en && !charge_on && r.cur == CUR_RST
	) else $error("power reset left charger state");

	xtal_stop_a: assert property (
		!xtal_ok |=> r.st == CHG_OFF && !r.en && !r.temp_ev
	) else $error("oscillator loss left charging");

	warm_reset_a: assert property (
		!warm_reset_n |=> limit_reset && r.st == CHG_OFF && !r.en
	) else $error("warm reset not handled");

	kick_mode_a: assert property (
		wr && paddr == OFF_WDOG && !all_clr && !wd_expired
		|=> r.sw_mode && wd_left == $past(pwdata[6:0])
	) else $error("watchdog write not taken");

	setting_keep_a: assert property (
		wr && paddr == OFF_SET && !all_clr && !wd_expired
		|=> r.cur == $past(pwdata[3:0]) && r.en == $past(r.en)
	) else $error("setting write disturbed charging");

	enable_load_a: assert property (
		wr && paddr == OFF_CTRL && pwdata[0] && !r.en && !all_clr
		&& !wd_expired |=> r.en && wd_left == $past(r.wtime)
	) else $error("enable did not load watchdog");

	disable_clear_a: assert property (
		wr && paddr == OFF_CTRL && !pwdata[0]
		|=> r.st == CHG_OFF && r.wtime == WDOG_RST && !charge_on
	) else $error("disable did not clear group");

	temp_gate_a: assert property (
		!temp_ok && r.st != CHG_OFF |=> r.st != CHG_RUN
	) else $error("charging not gated by temperature");

	dead_start_a: assert property (
		r.st == CHG_OFF && !temp_ok |=> !charge_on
	) else $error("charging started outside window");

	cross_flag_a: assert property (
		temp_cross && !all_clr |=> r.temp_ev ##1
		(r.temp_ev || $past(wr) || $past(all_clr))
	) else $error("temperature crossing lost");
	irq_mask_a: assert property (
		wr && paddr == OFF_CTRL && pwdata[2] && !all_clr |=> !temp_irq
	) else $error("masked event still raised");

	mon_active_a: assert property (
		charge_on |-> $past(temp_mon_en) && $past(temp_ok)
	) else $error("charging without monitor and window");
endmodule // charge_state_supervisor

// ==== charger_model.sv ====
// Charger side: supply detection and thermistor window comparators
`timescale 1ns/1ps
module charger_model #(
	parameter int COLD_LIM = 0,
	parameter int HOT_LIM  = 60
) (
	// Environment
	input  wire logic [1:0]        plugged,
	input  wire logic signed [7:0] temp_c,
	// Detection and comparators
	output logic                   vbus_det,
	output logic                   ext_chg_det,
	output logic                   temp_cold_ok,
	output logic                   temp_hot_ok
);
	// Detection follows the plugged sources
	assign vbus_det     = plugged[0];
	assign ext_chg_det  = plugged[1];
	// Each comparator sees one limit only
	assign temp_cold_ok = temp_c > COLD_LIM;
	assign temp_hot_ok  = temp_c < HOT_LIM;
endmodule // charger_model

// ==== testbench.sv ====
// Testbench for the charge state supervisor
`timescale 1ns/1ps
module testbench;
	import charge_pkg::*;
	logic              pclk, presetn, psel, penable, pwrite;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, q;
	logic              pready, pslverr, perr;
	logic [3:0]        cause, cur;
	logic [5:0]        volt;
	logic              xtal_ok, warm_reset_n, gate_dis;
	logic [1:0]        plugged;
	logic signed [7:0] temp_c;
	logic              vbus, ext, cold_ok, hot_ok;
	logic              pwr_n, lim_rst, mon_en, charge_on, temp_irq;
	int                err_count, n_checks;

	charge_state_supervisor #(.TICK_CYCLES(4)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .prim_wdog_expired(cause[0]),
		.battery_low_threshold(cause[1]),
		.thermal_protect_flag(cause[2]), .pwr_off_req(cause[3]),
		.xtal_ok(xtal_ok), .warm_reset_n(warm_reset_n),
		.system_power_reset_n(pwr_n), .limit_reset(lim_rst),
		.vbus_det(vbus), .ext_chg_det(ext), .temp_cold_ok(cold_ok),
		.temp_hot_ok(hot_ok), .temp_gate_dis(gate_dis),
		.temp_mon_en(mon_en), .charge_on(charge_on),
		.charge_current_set(cur), .charge_voltage_set(volt),
		.temp_irq(temp_irq)
	);
	charger_model PEER (
		.plugged(plugged), .temp_c(temp_c), .vbus_det(vbus),
		.ext_chg_det(ext), .temp_cold_ok(cold_ok),
		.temp_hot_ok(hot_ok)
	);

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge pclk);
	endtask
	// Held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
		begin
			err_count++;
			end_sim();
		end
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic hit(input int i, input logic on);
		@(posedge pclk);
		if (i < 4)
			cause[i] <= on;
		else if (i == 4)
			xtal_ok <= !on;
		else
			warm_reset_n <= !on;
	endtask
	task automatic set_temp(input logic signed [7:0] t, input logic g);
		@(posedge pclk);
		temp_c <= t;
		gate_dis <= g;
		cyc(6);
	endtask

	task automatic t_regs();
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, OFF_WDOG, 32'h0);
		chk(q, {25'h0, WDOG_RST});
		apb(1'b1, 8'h10, 32'hffffffff);
		chk(perr, 1'b1);
		apb(1'b0, OFF_SET, 32'h0);
		chk(q, 32'h0);
		chk(pwr_n, 1'b1);
		chk(mon_en, 1'b1);
		$display("regs done");
	endtask
	task automatic t_run();
		apb(1'b1, OFF_CTRL, 32'h1);
		cyc(2);
		chk(charge_on, 1'b1);
		apb(1'b1, OFF_CTRL, 32'h3);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(q[STAT_SW_BIT], 1'b1);
		apb(1'b1, OFF_SET, 32'h2a05);
		cyc(1);
		chk(cur, 4'h5);
		chk(volt, 6'h2a);
		chk(charge_on, 1'b1);
		apb(1'b1, OFF_CTRL, 32'h0);
		cyc(1);
		chk(charge_on, 1'b0);
		chk(cur, 4'h0);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(q[STAT_SW_BIT], 1'b0);
		apb(1'b1, OFF_CTRL, 32'h1);
		apb(1'b1, OFF_WDOG, 32'h2);
		cyc(1);
		chk(charge_on, 1'b1);
		cyc(16);
		chk(charge_on, 1'b0);
		$display("run done");
	endtask
	task automatic t_temp();
		apb(1'b1, OFF_CTRL, 32'h1);
		cyc(2);
		chk(charge_on, 1'b1);
		set_temp(8'sd70, 1'b0);
		chk(charge_on, 1'b0);
		chk(temp_irq, 1'b1);
		apb(1'b1, OFF_STAT, 32'h10);
		cyc(1);
		chk(temp_irq, 1'b0);
		apb(1'b1, OFF_CTRL, 32'h5);
		set_temp(8'sd25, 1'b0);
		chk(charge_on, 1'b1);
		chk(temp_irq, 1'b0);
		apb(1'b1, OFF_CTRL, 32'h1);
		cyc(1);
		chk(temp_irq, 1'b1);
		set_temp(-8'sd10, 1'b1);
		chk(charge_on, 1'b1);
		set_temp(-8'sd10, 1'b0);
		chk(charge_on, 1'b0);
		apb(1'b1, OFF_CTRL, 32'h0);
		apb(1'b1, OFF_CTRL, 32'h1);
		cyc(4);
		chk(charge_on, 1'b0);
		set_temp(8'sd25, 1'b0);
		chk(charge_on, 1'b1);
		@(posedge pclk);
		plugged <= 2'b00;
		cyc(4);
		chk(mon_en, 1'b0);
		chk(charge_on, 1'b0);
		@(posedge pclk);
		plugged <= 2'b10;
		cyc(4);
		chk(mon_en, 1'b1);
		$display("temp done");
	endtask
	// Four power causes, then crystal loss, then warm reset
	task automatic t_pwr();
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b1, OFF_CTRL, 32'h1);
			apb(1'b1, OFF_SET, 32'h0107);
			cyc(2);
			chk(charge_on, 1'b1);
			hit(i, 1'b1);
			cyc(3);
			chk(pwr_n, i > 3);
			chk(lim_rst, i == 5);
			chk(charge_on, 1'b0);
			chk(cur, 4'h0);
			hit(i, 1'b0);
			cyc(3);
			chk(lim_rst, 1'b0);
			apb(1'b0, OFF_CTRL, 32'h0);
			chk(q, 32'h0);
		end
		$display("power done");
	endtask

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cause = 4'h0;
		xtal_ok = 1'b1;
		warm_reset_n = 1'b1;
		gate_dis = 1'b0;
		plugged = 2'b01;
		temp_c = 8'sd25;
		err_count = 0;
		n_checks = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		cyc(4);
		t_regs();
		t_run();
		t_temp();
		t_pwr();
		end_sim();
	end
endmodule // testbench
